// ==== hdl/sa_pkg.sv ====
// shared constants for the step attenuator control port
package sa_pkg;
    // frame layout: attenuation word in bits 7..0, address word in bits 15..8
    localparam int FRAME_W = 16;
    localparam int ATT_W = 6;
    localparam int STRAP_W = 3;
    localparam int ATT_LO = 1;
    localparam int ATT_HI = 6;
    localparam int ADDR_LO = 8;
    localparam int ADDR_HI = 10;
    localparam int FRAME_MSB = 15;
    // attenuation codes in half-dB steps
    localparam logic [5:0] ATT_MAX = 6'h3F;
    localparam logic [5:0] ATT_REF = 6'h00;
    localparam logic [15:0] FRAME_RST = 16'h0000;
    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int DIRECT_DELAY_NS = 4000;
    localparam int DIRECT_DELAY_CYC = DIRECT_DELAY_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 10;
    // cycles after reset release before synchronised pins are trusted
    localparam int SETTLE_CYC = 3;
    // pin synchroniser width: select, strobe, data, clock, out pin, three straps
    localparam int PIN_W = 8;
    localparam int PIN_SEL = 0;
    localparam int PIN_LE = 1;
    localparam int PIN_SDI = 2;
    localparam int PIN_SCLK = 3;
    localparam int PIN_SDO = 4;
    localparam int PIN_A0 = 5;
    localparam int PIN_A1 = 6;
    localparam int PIN_A2 = 7;
endpackage

// ==== hdl/sa_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sa_sync
    import sa_pkg::*;
#(
    parameter int WIDTH = PIN_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // asynchronous pins in, synchronised levels out
    input wire logic [WIDTH-1:0] pinAsync,
    output logic [WIDTH-1:0] pinSync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sa_sync_state_t;

    sa_sync_state_t state_ff;
    sa_sync_state_t nxt_state;

    // first stage feeds only the second stage
    always_comb begin
        nxt_state.meta = pinAsync;
        nxt_state.stable = state_ff.meta;
    end

    // register both stages
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign pinSync = state_ff.stable;
endmodule

// ==== hdl/sa_edge.sv ====
// rising edge finder for synchronised levels
`timescale 1ns/1ps
module sa_edge
    import sa_pkg::*;
#(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // level in, one-cycle rising pulse out
    input wire logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);
    typedef struct packed {
        logic [WIDTH-1:0] prev;
    } sa_edge_state_t;

    sa_edge_state_t state_ff;
    sa_edge_state_t nxt_state;

    // remember last level
    always_comb begin
        nxt_state.prev = level;
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rise = level & ~state_ff.prev;
endmodule

// ==== hdl/sa_ctrl.sv ====
// control port of a 6-bit step attenuator: serial addressable and parallel
// Operation
// [RL1] 16-bit shift register feeds latch on load
// [RL2] frame: attenuation byte first, then address, lsb-first
// [RL3] attenuation word equals dB times four
// [RL4] latch applies only when address matches straps
// [RL5] host sends unused frame bits as zero
// [RL6] serial input sampled on serial clock rise
// [RL7] serial output valid on falling clock edge
// [RL8] host holds strobe low, then pulses it
// [RL9] shift only while strobe low; rise transfers
// [RL10] select low parallel, high serial
// [RL11] six weighted parallel inputs share serial pins
// [RL12] latched parallel adopts inputs on strobe pulse
// [RL13] direct parallel follows inputs while strobe high
// [RL14] strobe low at power-up gives maximum
// [RL15] serial with strobe high starts at reference
// [RL16] floating strobe in parallel gives maximum
// [RL17] direct mode presets after four microseconds
// [RL18] floating direct inputs give 28 dB
// [RL19] host never switches modes on the fly
// [RL20] host lowers pins before serial-to-parallel change
// [RL21] host lowers pins, releases output before change
// [RL22] floating strap reads high, grounded low
// [RL23] oldest stage drives serial output for cascading
`timescale 1ns/1ps
module sa_ctrl
    import sa_pkg::*;
#(
    parameter int DIRECT_CYC = DIRECT_DELAY_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // mode select and strobe pins
    input wire logic parSerSel,
    input wire logic latchStrobe,
    // serial_in / par_weight_half_db and serial clock / par_weight_one_db
    input wire logic serialIn,
    input wire logic serialClk,
    // serial_out / par_weight_two_db, a two-way pin
    input wire logic serialOutIn,
    output logic serialOut,
    output logic serialOutOe,
    // address straps / par weights four, eight, sixteen dB
    input wire logic addrStrapBit0,
    input wire logic addrStrapBit1,
    input wire logic addrStrapBit2,
    // attenuation state in half-dB steps and current mode
    output logic [ATT_W-1:0] attenState,
    output logic serialMode
);
    typedef enum {
        ST_SETTLE,
        ST_DIRECT_WAIT,
        ST_RUN
    } sa_ctrl_fsm_t;

    typedef struct packed {
        sa_ctrl_fsm_t st;
        logic [CNT_W-1:0] cnt;
        logic [FRAME_W-1:0] frame;
        logic [ATT_W-1:0] atten;
        logic serial_out;
        logic sdoOe;
        logic serMode;
    } sa_ctrl_state_t;

    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);
    localparam logic [CNT_W-1:0] DIRECT_LAST = CNT_W'(DIRECT_CYC - 1);

    sa_ctrl_state_t state_ff;
    sa_ctrl_state_t nxt_state;
    logic [PIN_W-1:0] pinAsync;
    logic [PIN_W-1:0] pinSync;
    logic [1:0] edgeLevel;
    logic [1:0] edgeRise;
    logic selS;
    logic leS;
    logic sdiS;
    logic sclkRise;
    logic leRise;
    logic [STRAP_W-1:0] strapS;
    logic [ATT_W-1:0] parBits;
    logic addrHit;

    // weighted parallel code from the shared pins, lsb is half a dB
    function automatic logic [ATT_W-1:0] par_code(input logic [PIN_W-1:0] p);
        par_code = {p[PIN_A2], p[PIN_A1], p[PIN_A0], p[PIN_SDO], p[PIN_SCLK], p[PIN_SDI]};
    endfunction

    // attenuation word is dB times four, so half-dB code sits in bits 6..1
    function automatic logic [ATT_W-1:0] word_code(input logic [FRAME_W-1:0] f);
        word_code = f[ATT_HI:ATT_LO];
    endfunction

    // every pin crosses two flops before use
    assign pinAsync = {addrStrapBit2, addrStrapBit1, addrStrapBit0, serialOutIn,
                       serialClk, serialIn, latchStrobe, parSerSel};

    sa_sync #(
        .WIDTH(PIN_W)
    ) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .pinAsync(pinAsync),
        .pinSync(pinSync)
    );

    // edges of serial clock and strobe
    assign edgeLevel = {pinSync[PIN_LE], pinSync[PIN_SCLK]};

    sa_edge #(
        .WIDTH(2)
    ) u_edge (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .level(edgeLevel),
        .rise(edgeRise)
    );

    // decoded pin levels
    assign selS = pinSync[PIN_SEL];
    assign leS = pinSync[PIN_LE];
    assign sdiS = pinSync[PIN_SDI];
    assign sclkRise = edgeRise[0];
    assign leRise = edgeRise[1];
    assign strapS = {pinSync[PIN_A2], pinSync[PIN_A1], pinSync[PIN_A0]};
    assign parBits = par_code(pinSync);
    // [RL22] strap compare
    // straps come from the synchronised pins and are compared with frame bits 10..8
    assign addrHit = (state_ff.frame[ADDR_HI:ADDR_LO] == strapS);

    // next-state logic for the whole port
    always_comb begin
        nxt_state = state_ff;
        // [RL10] mode select
        nxt_state.serMode = selS;
        nxt_state.sdoOe = selS;
        case (state_ff.st)
            ST_SETTLE: begin
                nxt_state.cnt = state_ff.cnt + CNT_W'(1);
                if (state_ff.cnt == SETTLE_LAST) begin
                    nxt_state.cnt = '0;
                    nxt_state.st = ST_RUN;
                    if (selS && leS) begin
                        // [RL15] serial reference start
                        nxt_state.atten = ATT_REF;
                    end else if (!selS && leS) begin
                        // [RL17] direct preset delay
                        nxt_state.st = ST_DIRECT_WAIT;
                        nxt_state.atten = ATT_MAX;
                    end else begin
                        // [RL14] maximum at power-up
                        // [RL16] floating strobe reads low
                        nxt_state.atten = ATT_MAX;
                    end
                end
            end
            ST_DIRECT_WAIT: begin
                nxt_state.cnt = state_ff.cnt + CNT_W'(1);
                if (state_ff.cnt == DIRECT_LAST) begin
                    // [RL17] preset takes effect
                    // [RL18] open inputs give 28 dB
                    nxt_state.cnt = '0;
                    nxt_state.st = ST_RUN;
                    nxt_state.atten = parBits;
                end
            end
            ST_RUN: begin
                if (selS) begin
                    // [RL6] sample on clock rise
                    // [RL9] shift only with strobe low
                    if (sclkRise && !leS) begin
                        // [RL1] shift register step
                        // [RL2] first bit lands at bit 0
                        nxt_state.frame = {sdiS, state_ff.frame[FRAME_MSB:1]};
                        // [RL23] oldest bit drives output
                        // [RL7] valid before falling edge
                        nxt_state.serial_out = state_ff.frame[0];
                    end
                    // [RL4] address gated latch
                    // [RL3] word divided by two
                    if (leRise && addrHit) begin
                        nxt_state.atten = word_code(state_ff.frame);
                    end
                end else begin
                    // [RL11] weighted pins
                    // [RL13] direct follow
                    // [RL12] latched on strobe
                    if (leS) begin
                        nxt_state.atten = parBits;
                    end
                    nxt_state.serial_out = 1'b0;
                end
            end
            default: begin
                nxt_state.st = ST_SETTLE;
                nxt_state.cnt = '0;
            end
        endcase
    end

    // one register for all state
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_ff.st <= ST_SETTLE;
            state_ff.cnt <= '0;
            state_ff.frame <= FRAME_RST;
            state_ff.atten <= ATT_MAX;
            state_ff.serial_out <= 1'b0;
            state_ff.sdoOe <= 1'b0;
            state_ff.serMode <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // outputs straight from flops
    assign attenState = state_ff.atten;
    assign serialOut = state_ff.serial_out;
    assign serialOutOe = state_ff.sdoOe;
    assign serialMode = state_ff.serMode;

    // shifting step in serial run mode
    sequence s_shift_req;
        state_ff.st == ST_RUN && selS && sclkRise && !leS;
    endsequence

    // latch request in serial run mode
    sequence s_latch_req;
        state_ff.st == ST_RUN && selS && leRise;
    endsequence

    // end of power-up settling
    sequence s_settle_done;
        state_ff.st == ST_SETTLE && state_ff.cnt == SETTLE_LAST;
    endsequence

    // [RL1] shift step check
    a_shift_step: assert property (  // [RL1]
        @(posedge clk_sys) disable iff (!rstn)
        s_shift_req |=> state_ff.frame == {$past(sdiS), $past(state_ff.frame[FRAME_MSB:1])})
        else $error("shift register did not take the serial bit");

    // [RL9] no shift without clock edge or with strobe high
    a_shift_hold: assert property (  // [RL9]
        @(posedge clk_sys) disable iff (!rstn)
        (state_ff.st == ST_RUN && !(sclkRise && !leS)) |=> $stable(state_ff.frame))
        else $error("shift register moved without a clock edge");

    // [RL4] matching address applies the word
    a_addr_hit: assert property (  // [RL4]
        @(posedge clk_sys) disable iff (!rstn)
        (s_latch_req and addrHit) |=> attenState == $past(state_ff.frame[ATT_HI:ATT_LO]))
        else $error("matching frame not applied");

    // [RL4] foreign address leaves the state
    a_addr_miss: assert property (  // [RL4]
        @(posedge clk_sys) disable iff (!rstn)
        (state_ff.st == ST_RUN && selS && !addrHit && !(leRise && addrHit)) |=>
            $stable(attenState))
        else $error("attenuation changed without a matching frame");

    // [RL23] cascade output carries the oldest bit
    a_cascade_out: assert property (  // [RL23]
        @(posedge clk_sys) disable iff (!rstn)
        s_shift_req |=> serialOut == $past(state_ff.frame[0]))
        else $error("serial output does not carry the oldest bit");

    // [RL10] output pin driven only in serial mode
    a_out_enable: assert property (  // [RL10]
        @(posedge clk_sys) disable iff (!rstn)
        ##1 (serialOutOe == $past(selS)) && (serialMode == $past(selS)))
        else $error("output enable does not follow mode select");

    // [RL13] direct mode follows the pins
    a_direct_follow: assert property (  // [RL13]
        @(posedge clk_sys) disable iff (!rstn)
        (state_ff.st == ST_RUN && !selS && leS) |=> attenState == $past(parBits))
        else $error("direct parallel state does not follow pins");

    // [RL14] strobe low at power-up gives maximum
    a_powerup_max: assert property (  // [RL14]
        @(posedge clk_sys) disable iff (!rstn)
        (s_settle_done and !leS) |=> attenState == ATT_MAX ##1 state_ff.st == ST_RUN)
        else $error("power-up state not maximum");

    // [RL15] serial strobe high at power-up gives reference
    a_powerup_ref: assert property (  // [RL15]
        @(posedge clk_sys) disable iff (!rstn)
        (s_settle_done and (selS && leS)) |=> attenState == ATT_REF)
        else $error("serial power-up state not reference");

    // [RL17] direct preset held at maximum for the first eight cycles of the wait
    a_direct_wait: assert property (  // [RL17]
        @(posedge clk_sys) disable iff (!rstn)
        (s_settle_done and (!selS && leS)) |=>
            (state_ff.st == ST_DIRECT_WAIT && attenState == ATT_MAX)[*8])
        else $error("direct preset applied too early");

    // [RL17] wait ends after the full count
    a_direct_end: assert property (  // [RL17]
        @(posedge clk_sys) disable iff (!rstn)
        (state_ff.st == ST_DIRECT_WAIT && state_ff.cnt == DIRECT_LAST) |=>
            (state_ff.st == ST_RUN && attenState == $past(parBits)))
        else $error("direct preset not applied at end of wait");

    // parallel run with strobe low
    sequence s_par_idle;
        state_ff.st == ST_RUN && !selS && !leS;
    endsequence

    // [RL12] latched parallel holds with strobe low
    a_par_hold: assert property (  // [RL12]
        @(posedge clk_sys) disable iff (!rstn)
        s_par_idle |=> $stable(attenState))
        else $error("parallel state changed while strobe low");

    // [RL10] parallel mode leaves output low
    a_par_out_low: assert property (  // [RL10]
        @(posedge clk_sys) disable iff (!rstn)
        (state_ff.st == ST_RUN && !selS) |=> !serialOut)
        else $error("serial output driven in parallel mode");

    // [RL7] output stands between clock rises
    a_out_hold: assert property (  // [RL7]
        @(posedge clk_sys) disable iff (!rstn)
        (state_ff.st == ST_RUN && selS && !sclkRise) |=> $stable(serialOut))
        else $error("serial output moved between clock rises");

    // [RL22] foreign strap address ignored
    a_strap_miss: assert property (  // [RL22]
        @(posedge clk_sys) disable iff (!rstn)
        (s_latch_req and !addrHit) |=> $stable(attenState))
        else $error("frame for another address applied");

    // [RL14] maximum held while settling
    a_settle_max: assert property (  // [RL14]
        @(posedge clk_sys) disable iff (!rstn)
        (state_ff.st == ST_SETTLE) |-> attenState == ATT_MAX)
        else $error("attenuation not maximum while settling");

    // [RL17] maximum held through the whole wait
    a_wait_max: assert property (  // [RL17]
        @(posedge clk_sys) disable iff (!rstn)
        (state_ff.st == ST_DIRECT_WAIT && state_ff.cnt != DIRECT_LAST) |=>
            attenState == ATT_MAX)
        else $error("direct preset applied before the wait ended");
endmodule

// ==== bench/sa_host.sv ====
// host controller model driving the attenuator control pins
`timescale 1ns/1ps
module sa_host (
    // clock
    input wire logic clk_sys,
    // pins driven by the host
    output logic parSerSel,
    output logic latchStrobe,
    output logic serialIn,
    output logic serialClk,
    output logic weightTwo,
    output logic [2:0] strap,
    // serial output level seen at each falling serial clock edge
    output logic [15:0] seenOut,
    input wire logic serialOutIn
);
    // wait n system clocks, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // pin levels fixed before power-up, mode select never switched in run
    task automatic preset(input logic sel, input logic le, input logic [5:0] w);
        parSerSel = sel;
        latchStrobe = le;
        {strap, weightTwo, serialClk, serialIn} = w;
    endtask

    // lsb-first frame, spare bits low, then strobe pulse
    task automatic send(input logic [2:0] adr, input logic [5:0] att, input logic le);
        logic [15:0] frm;
        frm = {5'h00, adr, 1'h0, att, 1'h0};
        latchStrobe = le;
        for (int k = 0; k < 16; k++) begin
            serialIn = frm[k];
            tick(12);
            serialClk = 1'h1;
            tick(13);
            seenOut[k] = serialOutIn;
            serialClk = 1'h0;
        end
        tick(12);
        latchStrobe = 1'h0;
        serialIn = ~frm[15];
        tick(8);
        latchStrobe = 1'h1;
        tick(8);
        latchStrobe = 1'h0;
        tick(12);
    endtask

    // change weights at the current strobe level, optionally pulse it
    task automatic par(input logic [5:0] w, input logic pulse);
        {strap, weightTwo, serialClk, serialIn} = w;
        tick(4);
        if (pulse) begin
            latchStrobe = 1'h1;
            tick(8);
            latchStrobe = 1'h0;
            tick(4);
        end
    endtask
endmodule

// ==== bench/sa_ctrl_bench.sv ====
// self-checking bench for the step attenuator control port
`timescale 1ns/1ps
`define CHK(what, exp, got) begin nTests++; if ((got) !== (exp)) begin nFail++; \
    $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); end end
module sa_ctrl_bench
    import sa_pkg::*;
;
    localparam int DCYC = 10;
    logic clk_sys;
    logic rstn;
    logic parSerSel, latchStrobe, serialIn, serialClk, weightTwo;
    logic serialOutIn, serialOut, serialOutOe, serialMode;
    logic [2:0] strap;
    logic [5:0] attenState;
    logic [15:0] seenOut;
    int nFail = 0;
    int nTests = 0;

    // shared output pin: device drives it in serial mode, host otherwise
    assign serialOutIn = serialOutOe ? serialOut : weightTwo;

    // design under test with a short direct-mode preset delay
    sa_ctrl #(.DIRECT_CYC(DCYC)) u_sa_ctrl (
        .clk_sys(clk_sys), .rstn(rstn), .parSerSel(parSerSel),
        .latchStrobe(latchStrobe), .serialIn(serialIn), .serialClk(serialClk),
        .serialOutIn(serialOutIn), .serialOut(serialOut), .serialOutOe(serialOutOe),
        .addrStrapBit0(strap[0]), .addrStrapBit1(strap[1]), .addrStrapBit2(strap[2]),
        .attenState(attenState), .serialMode(serialMode)
    );

    // host model on the control pins
    sa_host u_sa_host (
        .clk_sys(clk_sys), .parSerSel(parSerSel), .latchStrobe(latchStrobe),
        .serialIn(serialIn), .serialClk(serialClk), .weightTwo(weightTwo),
        .strap(strap), .seenOut(seenOut), .serialOutIn(serialOutIn)
    );

    // 200 MHz system clock
    initial begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // print counts and verdict, then stop
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", nTests, nFail);
        if (nFail == 0 && nTests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // pins set while held in reset, then released
    task automatic power_up(input logic sel, input logic le, input logic [5:0] w);
        rstn = 1'h0;
        u_sa_host.preset(sel, le, w);
        u_sa_host.tick(20);
        rstn = 1'h1;
        u_sa_host.tick(6);
    endtask

    // serial mode: power-up, addressed frames, cascade output, frozen shifting
    task automatic t_serial();
        power_up(1'h1, 1'h0, 6'h18);
        `CHK("maxAtPowerUp", ATT_MAX, attenState)
        `CHK("serialMode", 1'h1, serialMode)
        `CHK("outEnable", 1'h1, serialOutOe)
        // 18.5 dB gives word 74, state 37 half-dB steps
        u_sa_host.send(3'h3, 6'h25, 1'h0);
        `CHK("matchApplied", 6'h25, attenState)
        u_sa_host.send(3'h2, 6'h11, 1'h0);
        `CHK("cascadeOut", 16'h034A, seenOut)
        `CHK("mismatchKept", 6'h25, attenState)
        u_sa_host.send(3'h3, 6'h07, 1'h1);
        `CHK("frozenWhileHigh", 6'h25, attenState)
    endtask

    // serial mode with strobe high at power-up
    task automatic t_serial_ref();
        power_up(1'h1, 1'h1, 6'h00);
        `CHK("refAtPowerUp", ATT_REF, attenState)
    endtask

    // latched parallel: hold until pulse, each weight alone
    task automatic t_latched();
        power_up(1'h0, 1'h0, 6'h00);
        `CHK("latchedMax", ATT_MAX, attenState)
        `CHK("parallelMode", 1'h0, serialMode)
        `CHK("outReleased", 1'h0, serialOutOe)
        u_sa_host.par(6'h2A, 1'h0);
        `CHK("noPulseKept", ATT_MAX, attenState)
        u_sa_host.par(6'h2A, 1'h1);
        `CHK("pulseApplied", 6'h2A, attenState)
        for (int i = 0; i < 6; i++) begin
            u_sa_host.par(6'(1 << i), 1'h1);
            `CHK("weight", 6'(1 << i), attenState)
        end
    endtask

    // direct parallel: delayed preset, transparent following, floating pins
    task automatic t_direct();
        power_up(1'h0, 1'h1, 6'h15);
        `CHK("directWaiting", ATT_MAX, attenState)
        u_sa_host.tick(DCYC + 5);
        `CHK("directPreset", 6'h15, attenState)
        u_sa_host.par(6'h2C, 1'h0);
        `CHK("directFollow", 6'h2C, attenState)
        power_up(1'h0, 1'h1, 6'h38);
        u_sa_host.tick(DCYC + 5);
        `CHK("floatingPreset", 6'h38, attenState)
    endtask

    // main sequence
    initial begin
        t_serial();
        t_serial_ref();
        t_latched();
        t_direct();
        report_and_stop();
    end

    // cut a hang short
    initial begin
        repeat (100000) @(posedge clk_sys);
        nFail++;
        report_and_stop();
    end
endmodule
